// >>> trc_drive_model.sv
/*
  trc_drive_model: drive core and trip source stand-in around trc_top.
  assumes bench requests change after a rising hclk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module trc_drive_model
  import trc_pkg::*;
(
  input  wire logic           hclk,       // clock
  input  wire logic           hresetn,    // reset, low
  input  wire trc_pkg::trc_trip_s fire,   // new trips
  input  wire logic           drop,       // remove trips
  input  wire logic           trip_reset, // clear from block
  input  wire logic           fail_req,   // one failed search
  input  wire logic           match_req,  // search matched
  input  wire logic [3:0]     st,         // run, rev, hot, above base
  output var trc_pkg::trc_trip_s trip,    // trip levels
  output var trc_pkg::trc_drv_s  drv      // drive status
);
  // ---------------------------------------------------------------
  // trips stay until the block clears them or drop removes them
  // ---------------------------------------------------------------
  trc_trip_s held_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) held_q <= '0;
    else if (trip_reset || drop) held_q <= '0;
    else held_q <= held_q | fire;
  end
  // a reset pulse drops the trip at once, so it is not counted twice
  always_comb trip = trip_reset ? '0 : held_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) drv <= '0;
    else drv <= {st[3], st[2], st[1], match_req, fail_req, st[0]};
  end
endmodule
`default_nettype wire

// >>> trc_pkg.sv
/*
  trc_pkg: constants and carrier types for the trip retry and start control block.
  assumes a 100 MHz hclk and 32-bit AHB-Lite register access.
*/
package trc_pkg;

  // ---------------------------------------------------------------
  // register map (byte offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;  // retry count, fan, profile, search mode
  localparam logic [7:0] OFS_IVAL   = 8'h04;  // retry interval, tenths of seconds
  localparam logic [7:0] OFS_SFREQ  = 8'h08;  // search frequency (high half) / fall rate (low half)
  localparam logic [7:0] OFS_STATUS = 8'h0C;  // block state
  localparam logic [7:0] OFS_CMD    = 8'h10;  // clear alarm

  // ---------------------------------------------------------------
  // field positions in ctrl
  // ---------------------------------------------------------------
  localparam int CTRL_RETRY_LSB  = 0;   // 4 bits
  localparam int CTRL_FAN_BIT    = 4;
  localparam int CTRL_PROF_LSB   = 8;   // 2 bits
  localparam int CTRL_SRCH_LSB   = 12;  // 3 bits
  localparam int CTRL_FCL_BIT    = 16;
  localparam int CTRL_TRYTRM_LSB = 20;  // 3 bits, output terminal with retry status
  localparam int CTRL_STMTRM_LSB = 24;  // 3 bits, input terminal with start mode

  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] IVAL_RST  = 32'h0000_0005;
  localparam logic [31:0] SFREQ_RST = 32'h03E7_0001;

  // ---------------------------------------------------------------
  // codes
  // ---------------------------------------------------------------
  localparam logic [3:0]  RETRY_MAX       = 4'hA;
  localparam logic [11:0] IVAL_MIN        = 12'h005;   // 0.5 s
  localparam logic [11:0] IVAL_MAX        = 12'h0C8;   // 20.0 s
  localparam logic [15:0] SEARCH_FMAX     = 16'h03E7;  // 999 means start at fmax
  localparam logic [7:0]  TERM_FUNC_CODE  = 8'h1A;     // 26, routing code
  localparam logic [2:0]  SEARCH_FAIL_MAX = 3'h7;
  localparam logic [2:0]  TERM_NONE       = 3'h7;      // no terminal carries the function

  localparam real TICK_NS        = 10.0;
  localparam real DECISEC_NS     = 100000000.0;
  localparam int  DECISEC_CYC    = int'(DECISEC_NS / TICK_NS);
  localparam int  FAN_MIN_MIN    = 10;                 // minutes
  localparam int  FAN_MIN_DSEC   = FAN_MIN_MIN * 600;  // tenths of seconds

  typedef enum logic [1:0] {
    TRC_PROF_LINEAR = 2'h0,
    TRC_PROF_SWEAK  = 2'h1,
    TRC_PROF_SSTRNG = 2'h2,
    TRC_PROF_CURVE  = 2'h3
  } trc_prof_e;

  typedef enum logic [2:0] {
    TRC_SRCH_OFF = 3'h0,
    TRC_SRCH_FWD = 3'h3,
    TRC_SRCH_BI  = 3'h4,
    TRC_SRCH_REV = 3'h5
  } trc_srch_e;

  // trip sources; all but other are retryable
  typedef struct packed {
    logic ovcur;
    logic ovvolt;
    logic hs_heat;
    logic drv_heat;
    logic mot_heat;
    logic mot_load;
    logic drv_load;
    logic other;
  } trc_trip_s;

  // drive status from the ramp and current-limit core
  typedef struct packed {
    logic run_cmd;
    logic run_rev;
    logic hot;
    logic matched;
    logic srch_fail;
    logic above_base;
  } trc_drv_s;

  // start plan for the ramp generator
  typedef struct packed {
    logic       start;
    logic       search;
    logic       srch_rev;
    logic       use_fmax;
    logic       bidir;
    logic       cur_limit;
    trc_prof_e  profile;
    logic [6:0] inflect_pct;
    logic [7:0] stretch_pct;
    logic       taper;
  } trc_plan_s;

endpackage

// >>> trc_top.sv
/*
  trc_top: trip auto-reset, cooling fan control, ramp profile select and
  start-mode / speed search control for a motor drive.
  assumes: AHB-Lite single word slave on hclk, terminals from pins, drive core same clock.
*/
// Chosen here: the placing of the registers and the AHB-Lite slave port.
// Notes on behaviour
// [RL1] retryable trip is cleared and drive restarts with no alarm
// [RL2] trips beyond the retry count raise alarm, no further auto reset
// [RL3] retry count 1 to 10 accepted, 0 disables retry
// [RL4] wait the reset interval 0.5 to 20.0 s before each reset
// [RL5] only the seven listed protective trips are retried
// [RL6] retry status may be routed to a chosen output terminal, code 26
// [RL7] fan control 1 stops fan when stopped and cool; 0 always on
// [RL8] fan runs at least 10 minutes once started
// [RL9] profile code 0 linear, 1 weak S, 2 strong S, 3 curvilinear
// [RL10] S-curve zones are 5 or 10 percent of maximum frequency
// [RL11] ramp time sets linear part; total 1.1 or 1.2 times
// [RL12] curvilinear ramps linearly below base, tapered above base
// [RL13] start mode input routed with code 26, absent means asserted
// [RL14] mode 0 starts normally; 3,4,5 search only if start mode asserted
// [RL15] search lowers frequency under current limit, then ramps normally
// [RL16] search frequency 999 starts search at maximum frequency
// [RL17] mode 3 and 4 follow command direction, 5 starts opposite
// [RL18] bidirectional patterns retry from the opposite direction on failure
// [RL19] search fall rate equals the frequency fall rate setting
// [RL20] the configurer enables fast current limit whenever search is used
// [RL21] seven consecutive failed searches raise an alarm and stop
`timescale 1ns/1ps
`default_nettype none

module trc_top
  import trc_pkg::*;
#(
  parameter int DSEC_CYC = DECISEC_CYC  // cycles per tenth of a second
) (
  input  wire logic             hclk,        // 100 MHz clock
  input  wire logic             hresetn,     // async reset, low
  input  wire logic             hsel,        // slave select
  input  wire logic [7:0]       haddr,       // byte address
  input  wire logic [1:0]       htrans,      // transfer type
  input  wire logic             hwrite,      // write
  input  wire logic [2:0]       hsize,       // size
  input  wire logic [31:0]      hwdata,      // write data
  input  wire logic             hready,      // bus ready
  output logic [31:0]           hrdata,      // read data
  output logic                  hreadyout,   // slave ready
  output logic                  hresp,       // always okay
  input  wire trc_pkg::trc_trip_s trip,      // trip sources
  input  wire trc_pkg::trc_drv_s  drv,       // drive status
  input  wire logic [4:0]       din,         // digital input terminals
  output logic [4:0]            dout,        // digital output terminals
  output logic                  trip_reset,  // pulse, clear tripped state
  output logic                  alarm,       // alarm held
  output logic                  search_alarm,// search failed alarm
  output logic                  fan_on,      // cooling fan
  output trc_pkg::trc_plan_s    plan,        // start plan
  output logic [15:0]           fall_rate,   // search fall rate
  output logic [15:0]           search_freq  // search start frequency
);

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  logic [31:0] ctrl_q, ival_q, sfreq_q;
  logic [7:0]  wad_q;
  logic        wen_q, clr_q;
  logic        acc;

  assign acc       = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wen_q <= 1'b0;
      wad_q <= 8'h00;
    end else begin
      wen_q <= acc & hwrite;
      wad_q <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q  <= CTRL_RST;
      ival_q  <= IVAL_RST;
      sfreq_q <= SFREQ_RST;
    end else if (wen_q) begin
      unique case (wad_q)
        OFS_CTRL:  ctrl_q  <= hwdata;
        OFS_IVAL:  ival_q  <= hwdata;
        OFS_SFREQ: sfreq_q <= hwdata;
        default: ;
      endcase
    end
  end

  assign clr_q = wen_q & (wad_q == OFS_CMD) & hwdata[0];

  logic [3:0]  retry_count_param;
  logic        fan_control_param;
  trc_prof_e   ramp_profile_param;
  logic [2:0]  speed_search_mode_param;
  logic [11:0] retry_interval_param;
  logic [15:0] search_frequency_param;
  logic [15:0] frequency_fall_rate_param;
  logic        fast_current_limit_param;
  logic [2:0]  try_term, stm_term;

  // retry count clamped to 10, 0 disables
  assign retry_count_param = (ctrl_q[CTRL_RETRY_LSB +: 4] > RETRY_MAX) ?
                             RETRY_MAX : ctrl_q[CTRL_RETRY_LSB +: 4]; // RL3
  assign fan_control_param       = ctrl_q[CTRL_FAN_BIT];
  assign ramp_profile_param      = trc_prof_e'(ctrl_q[CTRL_PROF_LSB +: 2]); // RL9
  assign speed_search_mode_param = ctrl_q[CTRL_SRCH_LSB +: 3];
  assign fast_current_limit_param = ctrl_q[CTRL_FCL_BIT];
  assign try_term                = ctrl_q[CTRL_TRYTRM_LSB +: 3];
  assign stm_term                = ctrl_q[CTRL_STMTRM_LSB +: 3];
  // interval held inside 0.5 to 20.0 s
  assign retry_interval_param = (ival_q[11:0] < IVAL_MIN) ? IVAL_MIN :
                                (ival_q[11:0] > IVAL_MAX) ? IVAL_MAX : ival_q[11:0]; // RL4
  assign search_frequency_param    = sfreq_q[31:16];
  assign frequency_fall_rate_param = sfreq_q[15:0];

  // ---------------------------------------------------------------
  // input terminal synchronisers
  // ---------------------------------------------------------------
  logic [4:0] din1_q, din2_q, din3_q, dins_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      din1_q <= 5'h00;
      din2_q <= 5'h00;
      din3_q <= 5'h00;
      dins_q <= 5'h00;
    end else begin
      din1_q <= din;
      din2_q <= din1_q;
      din3_q <= din2_q;
      for (int i = 0; i < 5; i++) begin
        if (din2_q[i] == din3_q[i]) dins_q[i] <= din3_q[i];
      end
    end
  end

  logic start_mode_select_input;
  // unrouted means asserted
  assign start_mode_select_input = (stm_term > 3'h4) ? 1'b1 : dins_q[stm_term]; // RL13

  // ---------------------------------------------------------------
  // tenth-second tick
  // ---------------------------------------------------------------
  logic [31:0] tick_cnt_q;
  logic        tick;

  assign tick = (tick_cnt_q == 32'(DSEC_CYC - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tick_cnt_q <= 32'h0000_0000;
    else if (tick) tick_cnt_q <= 32'h0000_0000;
    else tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
  end

  // ---------------------------------------------------------------
  // auto reset
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TRC_R_IDLE = 2'b00,
    TRC_R_WAIT = 2'b01,
    TRC_R_ALRM = 2'b11
  } trc_rst_e;

  trc_rst_e    rst_q;
  logic [3:0]  tries_q;
  logic [11:0] wait_q;
  logic        retryable, any_trip, reset_pulse_q, alarm_q;

  assign retryable = trip.ovcur | trip.ovvolt | trip.hs_heat | trip.drv_heat |
                     trip.mot_heat | trip.mot_load | trip.drv_load; // RL5
  assign any_trip  = retryable | trip.other;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_q         <= TRC_R_IDLE;
      tries_q       <= 4'h0;
      wait_q        <= 12'h000;
      reset_pulse_q <= 1'b0;
      alarm_q       <= 1'b0;
    end else begin
      reset_pulse_q <= 1'b0;
      unique case (rst_q)
        TRC_R_IDLE: begin
          if (trip.other || (any_trip && retry_count_param == 4'h0)) begin
            rst_q   <= TRC_R_ALRM; // RL5
            alarm_q <= 1'b1;
          end else if (retryable && tries_q >= retry_count_param) begin
            rst_q   <= TRC_R_ALRM; // RL2
            alarm_q <= 1'b1;
          end else if (retryable) begin
            rst_q   <= TRC_R_WAIT; // RL1
            wait_q  <= retry_interval_param;
            tries_q <= tries_q + 4'h1;
          end
        end
        TRC_R_WAIT: begin
          if (tick) begin
            if (wait_q <= 12'h001) begin
              rst_q         <= TRC_R_IDLE;
              reset_pulse_q <= 1'b1; // RL4
            end else begin
              wait_q <= wait_q - 12'h001;
            end
          end
        end
        TRC_R_ALRM: begin
          if (clr_q) begin
            rst_q   <= TRC_R_IDLE;
            alarm_q <= 1'b0;
            tries_q <= 4'h0;
          end
        end
        default: rst_q <= TRC_R_IDLE;
      endcase
    end
  end

  assign trip_reset = reset_pulse_q;
  logic retry_active_output;
  assign retry_active_output = (rst_q == TRC_R_WAIT) | (tries_q != 4'h0 && rst_q != TRC_R_ALRM);

  // retry status routed to the chosen output terminal
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) dout <= 5'h00;
    else begin
      for (int i = 0; i < 5; i++) begin
        dout[i] <= retry_active_output && (try_term == 3'(i)); // RL6
      end
    end
  end

  // ---------------------------------------------------------------
  // cooling fan
  // ---------------------------------------------------------------
  logic [15:0] fan_cnt_q;
  logic        fan_q, fan_need;

  assign fan_need = !fan_control_param || drv.run_cmd || drv.hot; // RL7

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fan_q     <= 1'b1;
      fan_cnt_q <= 16'(FAN_MIN_DSEC);
    end else if (fan_need) begin
      if (!fan_q) fan_cnt_q <= 16'(FAN_MIN_DSEC);
      fan_q <= 1'b1;
    end else if (fan_q) begin
      if (fan_cnt_q == 16'h0000) fan_q <= 1'b0; // RL8
      else if (tick) fan_cnt_q <= fan_cnt_q - 16'h0001;
    end
  end
  assign fan_on = fan_q;

  // ---------------------------------------------------------------
  // start mode and speed search
  // ---------------------------------------------------------------
  logic       run_d_q, srch_dir_q, start_q, srch_q;
  logic [2:0] fail_q;
  logic       search_alarm_q, search_en;

  assign search_en = (speed_search_mode_param == TRC_SRCH_FWD ||
                      speed_search_mode_param == TRC_SRCH_BI ||
                      speed_search_mode_param == TRC_SRCH_REV) && start_mode_select_input; // RL14

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_d_q        <= 1'b0;
      start_q        <= 1'b0;
      srch_q         <= 1'b0;
      srch_dir_q     <= 1'b0;
      fail_q         <= 3'h0;
      search_alarm_q <= 1'b0;
    end else begin
      run_d_q <= drv.run_cmd;
      start_q <= drv.run_cmd & !run_d_q;
      // clear first so that a failure in the same cycle still sets the alarm
      if (clr_q) search_alarm_q <= 1'b0;
      if (drv.run_cmd && !run_d_q) begin
        srch_q     <= search_en;
        srch_dir_q <= drv.run_rev ^ (speed_search_mode_param == TRC_SRCH_REV); // RL17
        fail_q     <= 3'h0;
      end else if (srch_q && drv.matched) begin
        srch_q <= 1'b0; // RL15
      end else if (srch_q && drv.srch_fail) begin
        if (fail_q == SEARCH_FAIL_MAX - 3'h1) begin
          srch_q         <= 1'b0;
          search_alarm_q <= 1'b1; // RL21
        end else begin
          fail_q <= fail_q + 3'h1;
          if (speed_search_mode_param != TRC_SRCH_FWD && fail_q == 3'h0)
            srch_dir_q <= !srch_dir_q; // RL18
        end
      end
    end
  end

  assign search_alarm = search_alarm_q;
  assign alarm        = alarm_q | search_alarm_q;
  assign fall_rate    = frequency_fall_rate_param; // RL19
  assign search_freq  = search_frequency_param;

  always_comb begin
    plan           = '0;
    plan.start     = start_q;
    plan.search    = srch_q;
    plan.srch_rev  = srch_dir_q;
    plan.use_fmax  = (search_frequency_param == SEARCH_FMAX); // RL16
    plan.bidir     = (speed_search_mode_param == TRC_SRCH_BI) ||
                     (speed_search_mode_param == TRC_SRCH_REV); // RL18
    // limiting held only while searching; the configurer enables it
    plan.cur_limit = srch_q & fast_current_limit_param; // RL15 RL20
    plan.profile   = ramp_profile_param;
    unique case (ramp_profile_param)
      TRC_PROF_SWEAK: begin
        plan.inflect_pct = 7'd5; // RL10
        plan.stretch_pct = 8'd110; // RL11
      end
      TRC_PROF_SSTRNG: begin
        plan.inflect_pct = 7'd10; // RL10
        plan.stretch_pct = 8'd120; // RL11
      end
      TRC_PROF_CURVE: begin
        plan.stretch_pct = 8'd100;
        plan.taper       = drv.above_base; // RL12
      end
      TRC_PROF_LINEAR: plan.stretch_pct = 8'd100;
    endcase
  end

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h0000_0000;
    else if (acc && !hwrite) begin
      unique case (haddr)
        OFS_CTRL:   hrdata <= ctrl_q;
        OFS_IVAL:   hrdata <= ival_q;
        OFS_SFREQ:  hrdata <= sfreq_q;
        OFS_STATUS: hrdata <= {16'h0000, 1'b0, fail_q, tries_q, fan_q, srch_q,
                               search_alarm_q, alarm_q, 2'b00, rst_q};
        default:    hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_no_retry_zero;
    @(posedge hclk) disable iff (!hresetn)
      (rst_q == TRC_R_IDLE && retryable && retry_count_param == 4'h0) |=> alarm_q;
  endproperty
  a_no_retry_zero: assert property (p_no_retry_zero) else $error("zero count retried"); // RL3

  property p_other_alarm;
    @(posedge hclk) disable iff (!hresetn)
      (rst_q == TRC_R_IDLE && trip.other) |=> (rst_q == TRC_R_ALRM);
  endproperty
  a_other_alarm: assert property (p_other_alarm) else $error("other fault retried"); // RL5

  property p_retry_wait;
    @(posedge hclk) disable iff (!hresetn)
      (rst_q == TRC_R_IDLE && retryable && !trip.other && tries_q < retry_count_param)
        |=> (rst_q == TRC_R_WAIT && !alarm_q);
  endproperty
  a_retry_wait: assert property (p_retry_wait) else $error("retry not started"); // RL1

  property p_exceed;
    @(posedge hclk) disable iff (!hresetn)
      (rst_q == TRC_R_IDLE && retryable && tries_q >= retry_count_param) |=> alarm_q;
  endproperty
  a_exceed: assert property (p_exceed) else $error("no alarm past count"); // RL2

  property p_no_reset_in_alarm;
    @(posedge hclk) disable iff (!hresetn)
      (rst_q == TRC_R_ALRM) |=> !trip_reset;
  endproperty
  a_no_reset_in_alarm: assert property (p_no_reset_in_alarm) else $error("reset in alarm"); // RL2

  property p_fan_always;
    @(posedge hclk) disable iff (!hresetn)
      !fan_control_param |=> fan_on;
  endproperty
  a_fan_always: assert property (p_fan_always) else $error("fan off while forced"); // RL7

  property p_fan_min;
    @(posedge hclk) disable iff (!hresetn)
      ($fell(fan_q)) |-> ($past(fan_cnt_q) == 16'h0000);
  endproperty
  a_fan_min: assert property (p_fan_min) else $error("fan stopped early"); // RL8

  property p_unrouted_stm;
    @(posedge hclk) disable iff (!hresetn)
      (drv.run_cmd && !run_d_q && stm_term == TERM_NONE && speed_search_mode_param == 3'h3)
        |=> srch_q;
  endproperty
  a_unrouted_stm: assert property (p_unrouted_stm) else $error("unrouted not asserted"); // RL13

  property p_mode0;
    @(posedge hclk) disable iff (!hresetn)
      (drv.run_cmd && !run_d_q && speed_search_mode_param == 3'h0) |=> !srch_q;
  endproperty
  a_mode0: assert property (p_mode0) else $error("searched in mode 0"); // RL14

endmodule

`default_nettype wire

// >>> trc_top_bench.sv
/*
  trc_top_bench: self-checking bench for trc_top.
  assumes DSEC_CYC of 10, AHB-Lite single words, expected values in a queue.
*/
`timescale 1ns/1ps
`default_nettype none
`define CMP(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module trc_top_bench;
  import trc_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, drop = 0, fail_req = 0, match_req = 0;
  logic [7:0]  haddr = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] hwdata = 0, hrdata;
  logic [4:0]  din = 0, dout;
  logic [3:0]  st = 0;
  logic        hreadyout, hresp, trip_reset, alarm, search_alarm, fan_on;
  logic [15:0] fall_rate, search_freq;
  trc_trip_s   fire = '0, trip;
  trc_drv_s    drv;
  trc_plan_s   plan;
  int          fails = 0, compares = 0;
  string       nm_q[$];
  logic [31:0] exp_q[$], seen;
  event        seen_ev;
  always #5 hclk = ~hclk;
  trc_top #(.DSEC_CYC(10)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .trip(trip), .drv(drv), .din(din),
    .dout(dout), .trip_reset(trip_reset), .alarm(alarm), .search_alarm(search_alarm),
    .fan_on(fan_on), .plan(plan), .fall_rate(fall_rate), .search_freq(search_freq));
  trc_drive_model partner (.hclk(hclk), .hresetn(hresetn), .fire(fire), .drop(drop),
    .trip_reset(trip_reset), .fail_req(fail_req), .match_req(match_req), .st(st),
    .trip(trip), .drv(drv));
  // ---------------------------------------------------------------
  // expectation queue and its watcher
  // ---------------------------------------------------------------
  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    nm_q.push_back(nm);
    exp_q.push_back(e);
    seen = g;
    ->seen_ev;
    #0;
  endtask
  always @(seen_ev) begin
    string n;
    logic [31:0] e;
    n = nm_q.pop_front();
    e = exp_q.pop_front();
    `CMP(n, e, seen)
  end
  task give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin fails++; give_verdict(); end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    check(nm, e, r);
  endtask
  task tick(input int k);
    repeat (k) @(posedge hclk);
  endtask
  task pulse_fire(input logic [7:0] m);
    fire <= m; tick(1); fire <= '0;
  endtask
  task clear_all;
    drop <= 1'b1; tick(1); drop <= 1'b0; st <= 4'h0;
    wr(OFS_CMD, 32'h0000_0001); tick(2);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    int n;
    int md[4];
    logic [15:0] fr;
    md = '{0, 3, 4, 5};
    void'($urandom(32'hece4ef53));
    tick(3); hresetn <= 1'b1; tick(1);
    rchk("ctrl", OFS_CTRL, CTRL_RST);
    rchk("ival", OFS_IVAL, IVAL_RST);
    rchk("sfreq", OFS_SFREQ, SFREQ_RST);
    wr(8'h20, 32'hFFFF_FFFF);
    rchk("unmapped", 8'h20, 32'h0000_0000);
    check("hresp", 0, hresp);
    check("fan_always", 1, fan_on);
    wr(OFS_CTRL, 32'h0721_0002);
    for (int i = 0; i < 3; i++) begin
      pulse_fire(8'h80);
      n = 0;
      while (trip_reset !== 1'b1 && n < 80) begin
        tick(1); n++;
        if (n == 20) check("retry_out", i < 2, dout[2]);
      end
      check("reset_seen", i < 2, n < 80);
      check("interval", 1, i == 2 || (n >= 39 && n <= 61));
      check("alarm", i == 2, alarm);
      tick(3);
    end
    clear_all();
    check("alarm_clr", 0, alarm);
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CTRL, i ? 32'h0721_0000 : 32'h0721_000A);
      pulse_fire(i ? 8'h80 : 8'h01); tick(10);
      check("no_retry", 1, alarm);
      check("no_reset", 0, trip_reset);
      clear_all();
    end
    fr = 16'($urandom);
    wr(OFS_SFREQ, {SEARCH_FMAX, fr});
    tick(1);
    check("fall", fr, fall_rate);
    check("sfreq", SEARCH_FMAX, search_freq);
    foreach (md[k]) for (int rv = 0; rv < 2; rv++) begin
      wr(OFS_CTRL, 32'h0711_0000 | (md[k] << 12));
      st <= {1'b1, rv[0], 2'b00}; tick(5);
      check("search", md[k] != 0, plan.search);
      check("bidir", md[k] >= 4, plan.bidir);
      check("limit", md[k] != 0, plan.cur_limit);
      if (md[k] != 0) check("dir", (md[k] == 5) ^ rv[0], plan.srch_rev);
      if (md[k] != 0) check("fmax", 1, plan.use_fmax);
      match_req <= 1'b1; tick(1); match_req <= 1'b0; st <= 4'h0; tick(5);
    end
    for (int d = 0; d < 2; d++) begin
      wr(OFS_CTRL, 32'h0011_3000);
      din <= 5'(d); tick(8); st <= 4'h8; tick(5);
      check("stm_input", d, plan.search);
      match_req <= 1'b1; tick(1); match_req <= 1'b0; st <= 4'h0; tick(5);
    end
    wr(OFS_CTRL, 32'h0711_4000);
    st <= 4'h8; tick(5);
    for (int f = 1; f <= 7; f++) begin
      fail_req <= 1'b1; tick(1); fail_req <= 1'b0; tick(4);
      if (f == 1) check("flip", 1, plan.srch_rev);
      check("srch_alarm", f == 7, search_alarm);
    end
    clear_all();
    for (int p = 0; p < 4; p++) begin
      wr(OFS_CTRL, 32'h0700_0000 | (p << 8));
      st <= 4'h1; tick(2);
      check("profile", p, plan.profile);
      if (p == 1 || p == 2) check("inflect", p * 5, plan.inflect_pct);
      check("stretch", (p == 1 || p == 2) ? 100 + p * 10 : 100, plan.stretch_pct);
      check("taper", p == 3, plan.taper);
    end
    wr(OFS_CTRL, 32'h0700_0010);
    st <= 4'h0; n = 0;
    while (fan_on !== 1'b0 && n < 70000) begin tick(1); n++; end
    check("fan_off", 1, n < 70000);
    check("fan_min", 1, n >= FAN_MIN_DSEC * 10 - 10);
    st <= 4'h2; tick(5);
    check("fan_hot", 1, fan_on);
    give_verdict();
  end
endmodule
`default_nettype wire
